// ===== spk_gain_pkg.sv
// Constants for the speaker output gain control block.
// Assumes a 9-bit register word written over the codec control interface.
package spk_gain_pkg;
  localparam int          REG_ADDR_W     = 7;
  localparam int          REG_DATA_W     = 9;
  localparam logic [6:0]  ADDR_SLOW_TICK = 7'h07;
  localparam logic [6:0]  ADDR_SPK_SRC   = 7'h32;
  localparam logic [6:0]  ADDR_SPK_GAIN  = 7'h36;
  localparam logic [8:0]  SLOW_TICK_RST  = 9'h000;
  localparam logic [8:0]  SPK_SRC_RST    = 9'h000;
  localparam logic [8:0]  SPK_GAIN_RST   = 9'h079;
  localparam logic [8:0]  RD_UNMAPPED    = 9'h000;
  localparam int          BIT_SLOW_EN    = 0;
  localparam int          BIT_CONV_SEL   = 0;
  localparam int          BIT_BYP_SEL    = 1;
  localparam int          BIT_AUX_SEL    = 5;
  localparam int          BIT_ZC         = 7;
  localparam int          BIT_MUTE       = 6;
  localparam int          BIT_ATTEN      = 8;
  localparam int          GAIN_MSB       = 5;
  localparam int          GAIN_W         = 6;
  localparam logic [5:0]  GAIN_0DB       = 6'h39;
  // Bypass attenuation of 10 dB as a ratio of 81/256 (0.3164).
  localparam int          ATTEN_MUL      = 81;
  localparam int          ATTEN_SHIFT    = 8;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          TIMEOUT_HZ     = 31;
  localparam int          TIMEOUT_CYCLES = CLK_HZ / TIMEOUT_HZ;
endpackage : spk_gain_pkg

// ===== slow_tick_gen.sv
// Slow tick generator used by the zero-cross timeout and the jack debounce.
// Assumes the main clock; emits one-cycle ticks only while enabled.
`timescale 1ns/1ps
module slow_tick_gen #(
  parameter int PERIOD = spk_gain_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Control and tick
  input  wire logic enable,
  output logic      tick
);
  import spk_gain_pkg::*;

  localparam int CW = $clog2(PERIOD + 1);

  logic [CW-1:0] count_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Restarting from zero on enable keeps the first timeout a full period.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enable) begin
      count_ff <= '0;
      tick     <= 1'b0;
    end else if (count_ff == CW'(PERIOD - 1)) begin
      count_ff <= '0;
      tick     <= 1'b1;
    end else begin
      count_ff <= count_ff + CW'(1);
      tick     <= 1'b0;
    end
  end
endmodule : slow_tick_gen

// ===== speaker_output_gain_control.sv
// Speaker mixer source selection, bypass attenuation, gain code and mute.
// Assumes register writes arrive as one-cycle strobes synchronous to sys_clk
// and that samples are signed two's complement with a qualifying strobe.
//
// Operation
// - Mix includes each source only when selected.
// - Bit 8 attenuates bypass into mix 10dB.
// - Six-bit gain code, 1dB steps, resets 0dB.
// - Mute holds both speaker outputs at mid-rail.
// - Zero-cross bit defers gain to a crossing.
// - Slow-clock timeout applies pending gain anyway.
// - Slow tick enable bit drives timeout, debounce.
// - Mono output inactive unless its enable set.
`timescale 1ns/1ps
module speaker_output_gain_control #(
  parameter int SAMPLE_W       = 16,
  parameter int TIMEOUT_CYCLES = spk_gain_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   sys_rst,
  // Control interface register port
  input  wire logic                                   reg_wr,
  input  wire logic [spk_gain_pkg::REG_ADDR_W-1:0]    reg_addr,
  input  wire logic [spk_gain_pkg::REG_DATA_W-1:0]    reg_wdata,
  output logic      [spk_gain_pkg::REG_DATA_W-1:0]    reg_rdata,
  // Source samples
  input  wire logic                                   sample_valid,
  input  wire logic signed [SAMPLE_W-1:0]             conv_sample,
  input  wire logic signed [SAMPLE_W-1:0]             bypass_sample,
  input  wire logic signed [SAMPLE_W-1:0]             aux_sample,
  // Mono path control
  input  wire logic                                   mono_out_en,
  input  wire logic [2:0]                             mono_src_sel,
  // Speaker outputs
  output logic signed [SAMPLE_W+1:0]                  spk_pos,
  output logic signed [SAMPLE_W+1:0]                  spk_neg,
  output logic [spk_gain_pkg::GAIN_W-1:0]             speaker_gain_code,
  output logic                                        speaker_silence,
  output logic                                        gain_pending,
  // Mono output and slow tick
  output logic signed [SAMPLE_W+1:0]                  mono_out,
  output logic                                        slow_tick
);
  import spk_gain_pkg::*;

  localparam int MW = SAMPLE_W + 2;
  localparam logic signed [MW-1:0] MID_RAIL = '0;

  logic [REG_DATA_W-1:0] slow_ctrl_ff;
  logic [REG_DATA_W-1:0] src_sel_ff;
  logic [REG_DATA_W-1:0] gain_ctrl_ff;
  logic [GAIN_W-1:0]     gain_applied_ff;
  logic                  pending_ff;
  logic                  last_neg_ff;
  logic                  seen_ff;
  logic                  crossing;
  logic                  gain_wr;
  logic                  slow_wr;
  logic                  src_wr;
  logic                  gain_now;
  logic                  gain_late;
  logic signed [MW-1:0]  spk_mix;
  logic signed [MW-1:0]  mono_mix;
  logic signed [MW-1:0]  byp_atten;

  ////////////////////////////////////////////////////////////////////////////
  // Sum of selected sources; sign-extends samples a and c to the mix width, b arrives already at it.
  function automatic logic signed [MW-1:0] mix3(
    input logic [2:0]                  sel,
    input logic signed [SAMPLE_W-1:0]  a,
    input logic signed [MW-1:0]        b,
    input logic signed [SAMPLE_W-1:0]  c
  );
    logic signed [MW-1:0] acc;
    acc = '0;
    if (sel[0]) acc = acc + MW'(a);
    if (sel[1]) acc = acc + b;
    if (sel[2]) acc = acc + MW'(c);
    return acc;
  endfunction : mix3

  // Address match for one mapped register; unmapped writes hit nothing.
  function automatic logic reg_hit(
    input logic                  wr,
    input logic [REG_ADDR_W-1:0] addr,
    input logic [REG_ADDR_W-1:0] target
  );
    return wr && (addr == target);
  endfunction : reg_hit

  // Truncating multiply-shift; the 0.005 dB error is inaudible here.
  always_comb begin
    byp_atten = MW'(bypass_sample);
    if (gain_ctrl_ff[BIT_ATTEN]) begin
      byp_atten = MW'((MW'(bypass_sample) * ATTEN_MUL) >>> ATTEN_SHIFT);
    end
  end

  assign spk_mix  = mix3({src_sel_ff[BIT_AUX_SEL], src_sel_ff[BIT_BYP_SEL],
                          src_sel_ff[BIT_CONV_SEL]},
                         conv_sample, byp_atten, aux_sample);
  assign mono_mix = mix3(mono_src_sel, conv_sample, MW'(bypass_sample), aux_sample);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, one register to a process.
  assign slow_wr  = reg_hit(reg_wr, reg_addr, ADDR_SLOW_TICK);
  assign src_wr   = reg_hit(reg_wr, reg_addr, ADDR_SPK_SRC);
  assign gain_wr  = reg_hit(reg_wr, reg_addr, ADDR_SPK_GAIN);
  assign gain_now = gain_wr && !reg_wdata[BIT_ZC];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slow_ctrl_ff <= SLOW_TICK_RST;
    end else if (slow_wr) begin
      slow_ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      src_sel_ff <= SPK_SRC_RST;
    end else if (src_wr) begin
      src_sel_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gain_ctrl_ff <= SPK_GAIN_RST;
    end else if (gain_wr) begin
      gain_ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= RD_UNMAPPED;
    end else begin
      unique case (reg_addr)
        ADDR_SLOW_TICK: reg_rdata <= slow_ctrl_ff;
        ADDR_SPK_SRC:   reg_rdata <= src_sel_ff;
        ADDR_SPK_GAIN:  reg_rdata <= gain_ctrl_ff;
        default:        reg_rdata <= RD_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow tick shared by the timeout and the jack debounce.
  slow_tick_gen #(
    .PERIOD (TIMEOUT_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .enable  (slow_ctrl_ff[BIT_SLOW_EN]),
    .tick    (slow_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Zero crossing on the speaker mix; the first sample after reset only primes.
  assign crossing = sample_valid && seen_ff && (spk_mix[MW-1] != last_neg_ff);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_neg_ff <= 1'b0;
    end else if (sample_valid) begin
      last_neg_ff <= spk_mix[MW-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seen_ff <= 1'b0;
    end else if (sample_valid) begin
      seen_ff <= 1'b1;
    end
  end

  // A zero-cross write in the same cycle as a crossing stays pending for the next one,
  // so the newest code is never dropped.
  assign gain_late = pending_ff && !gain_wr && (crossing || slow_tick);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pending_ff <= 1'b0;
    end else if (gain_wr) begin
      pending_ff <= reg_wdata[BIT_ZC];
    end else if (gain_late) begin
      pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gain_applied_ff <= GAIN_0DB;
    end else if (gain_now) begin
      gain_applied_ff <= reg_wdata[GAIN_MSB:0];
    end else if (gain_late) begin
      gain_applied_ff <= gain_ctrl_ff[GAIN_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spk_pos <= MID_RAIL;
      spk_neg <= MID_RAIL;
    end else begin
      spk_pos <= gain_ctrl_ff[BIT_MUTE] ? MID_RAIL : spk_mix;
      spk_neg <= gain_ctrl_ff[BIT_MUTE] ? MID_RAIL : -spk_mix;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mono_out <= MID_RAIL;
    end else begin
      mono_out <= mono_out_en ? mono_mix : MID_RAIL;
    end
  end

  assign speaker_gain_code = gain_applied_ff;
  assign speaker_silence   = gain_ctrl_ff[BIT_MUTE];
  assign gain_pending      = pending_ff;
endmodule : speaker_output_gain_control

// ===== speaker_output_gain_control_assertions.sv
// Checker for the speaker output gain control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module speaker_output_gain_control_assertions
  import spk_gain_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  // Clock, reset and register port
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic                       reg_wr,
  input wire logic [6:0]                 reg_addr,
  input wire logic [8:0]                 reg_wdata,
  input wire logic [8:0]                 reg_rdata,
  // Samples and outputs
  input wire logic                       sample_valid,
  input wire logic                       mono_out_en,
  input wire logic signed [SAMPLE_W+1:0] spk_pos,
  input wire logic signed [SAMPLE_W+1:0] spk_neg,
  input wire logic signed [SAMPLE_W+1:0] mono_out,
  input wire logic [5:0]                 speaker_gain_code,
  input wire logic                       speaker_silence,
  input wire logic                       gain_pending,
  input wire logic                       slow_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_gain_wr; reg_wr && reg_addr == ADDR_SPK_GAIN; endsequence
  property p_neg; spk_neg == -spk_pos; endproperty
  property p_mute; speaker_silence && $past(speaker_silence) |-> spk_pos == 0; endproperty
  property p_mono; !mono_out_en |=> mono_out == 0; endproperty
  property p_now; s_gain_wr ##0 !reg_wdata[7] |=>
    speaker_gain_code == $past(reg_wdata[5:0]) && !gain_pending; endproperty
  property p_zc; s_gain_wr ##0 reg_wdata[7] |=> gain_pending && $stable(speaker_gain_code);
  endproperty
  property p_hold; gain_pending && !sample_valid && !slow_tick && !reg_wr |=>
    gain_pending && $stable(speaker_gain_code); endproperty
  property p_tick; gain_pending && slow_tick && !reg_wr |=> !gain_pending; endproperty
  // The gap holds for any shortened period above eight cycles.
  property p_pulse; slow_tick |=> !slow_tick [*8]; endproperty
  property p_rd; reg_addr == ADDR_SPK_GAIN |=> reg_rdata[6] == $past(speaker_silence);
  endproperty
  a_neg: assert property (p_neg) else $error("spk_neg not inverse");
  a_mute: assert property (p_mute) else $error("muted output moved");
  a_mono: assert property (p_mono) else $error("mono active while off");
  a_now: assert property (p_now) else $error("direct gain wrong");
  a_zc: assert property (p_zc) else $error("deferred gain applied early");
  a_hold: assert property (p_hold) else $error("pending gain moved");
  a_tick: assert property (p_tick) else $error("timeout not applied");
  a_pulse: assert property (p_pulse) else $error("tick too close");
  a_rd: assert property (p_rd) else $error("readback wrong");
endmodule : speaker_output_gain_control_assertions
bind speaker_output_gain_control speaker_output_gain_control_assertions #(
  .SAMPLE_W (SAMPLE_W)
) u_speaker_output_gain_control_assertions (
  .sys_clk           (sys_clk),
  .sys_rst           (sys_rst),
  .reg_wr            (reg_wr),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_rdata         (reg_rdata),
  .sample_valid      (sample_valid),
  .mono_out_en       (mono_out_en),
  .spk_pos           (spk_pos),
  .spk_neg           (spk_neg),
  .mono_out          (mono_out),
  .speaker_gain_code (speaker_gain_code),
  .speaker_silence   (speaker_silence),
  .gain_pending      (gain_pending),
  .slow_tick         (slow_tick)
);

// ===== speaker_output_gain_control_bench.sv
// Self-checking bench for the speaker output gain control block.
// Assumes the package is compiled first; the timeout is cut to 20 cycles.
`timescale 1ns/1ps
module speaker_output_gain_control_bench;
  import spk_gain_pkg::*;
  localparam int TO = 20;
  logic               sys_clk, sys_rst, reg_wr, sample_valid, mono_out_en;
  logic               speaker_silence, gain_pending, slow_tick;
  logic [6:0]         reg_addr;
  logic [8:0]         reg_wdata, reg_rdata;
  logic [2:0]         mono_src_sel;
  logic [5:0]         speaker_gain_code;
  logic signed [15:0] conv_sample, bypass_sample, aux_sample;
  logic signed [17:0] spk_pos, spk_neg, mono_out;
  int                 n_fail, n_compared, e, k;
  speaker_output_gain_control #(
    .TIMEOUT_CYCLES (TO)
  ) u_speaker_output_gain_control (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .reg_wr            (reg_wr),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .sample_valid      (sample_valid),
    .conv_sample       (conv_sample),
    .bypass_sample     (bypass_sample),
    .aux_sample        (aux_sample),
    .mono_out_en       (mono_out_en),
    .mono_src_sel      (mono_src_sel),
    .spk_pos           (spk_pos),
    .spk_neg           (spk_neg),
    .speaker_gain_code (speaker_gain_code),
    .speaker_silence   (speaker_silence),
    .gain_pending      (gain_pending),
    .mono_out          (mono_out),
    .slow_tick         (slow_tick)
  );
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [8:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 chk(18'(reg_rdata), 18'(x));
  endtask : rd
  task automatic smp(input int c, input int b, input int x);
    @(posedge sys_clk);
    conv_sample   <= 16'(c);
    bypass_sample <= 16'(b);
    aux_sample    <= 16'(x);
    sample_valid  <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : smp
  task automatic t_mix;
    logic [8:0] sel[5] = '{9'h001, 9'h002, 9'h020, 9'h023, 9'h000};
    wr(ADDR_SPK_GAIN, 9'h039);
    chk(18'(speaker_silence), 18'h0);
    foreach (sel[i]) begin
      wr(ADDR_SPK_SRC, sel[i]);
      smp(100, 256, -7);
      e = (sel[i][0] ? 100 : 0) + (sel[i][1] ? 256 : 0) + (sel[i][5] ? -7 : 0);
      chk(spk_pos, 18'(e));
      chk(spk_neg, 18'(-e));
    end
    wr(ADDR_SPK_GAIN, 9'h139);
    wr(ADDR_SPK_SRC, 9'h002);
    smp(100, 256, -7);
    chk(spk_pos, 18'h51);
    wr(ADDR_SPK_GAIN, 9'h079);
    smp(100, 256, -7);
    chk(spk_pos | spk_neg, 18'h0);
    chk(18'(speaker_silence), 18'h1);
  endtask : t_mix
  task automatic t_gain;
    logic [5:0] cd[3] = '{6'h00, 6'h3F, 6'h39};
    foreach (cd[i]) begin
      wr(ADDR_SPK_GAIN, {3'h0, cd[i]});
      chk(18'({gain_pending, speaker_gain_code}), 18'(cd[i]));
    end
  endtask : t_gain
  // A crossing is only seen once a first valid sample has primed the sign.
  task automatic t_zc;
    wr(ADDR_SPK_SRC, 9'h001);
    rd(ADDR_SPK_SRC, 9'h001);
    smp(100, 0, 0);
    wr(ADDR_SPK_GAIN, 9'h0A0);
    smp(100, 0, 0);
    chk(18'({gain_pending, speaker_gain_code}), 18'h79);
    rd(ADDR_SPK_GAIN, 9'h0A0);
    smp(-100, 0, 0);
    chk(18'({gain_pending, speaker_gain_code}), 18'h20);
  endtask : t_zc
  task automatic t_timeout;
    wr(ADDR_SLOW_TICK, 9'h001);
    wr(ADDR_SPK_GAIN, 9'h091);
    for (k = 0; k < 2 * TO && gain_pending; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(18'({gain_pending, speaker_gain_code}), 18'h11);
    k = 0;
    repeat (2 * TO) begin
      @(posedge sys_clk);
      #1 k += slow_tick;
    end
    chk(18'(k), 18'h2);
    wr(ADDR_SLOW_TICK, 9'h000);
    k = 0;
    repeat (2 * TO) begin
      @(posedge sys_clk);
      #1 k += slow_tick;
    end
    chk(18'(k), 18'h0);
  endtask : t_timeout
  // A reset in mid-run drops a pending code and restores the gain, mute and slow tick defaults.
  task automatic t_reset;
    wr(ADDR_SLOW_TICK, 9'h001);
    wr(ADDR_SPK_GAIN, 9'h095);
    chk(18'({speaker_silence, gain_pending}), 18'h1);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 chk(18'({speaker_silence, gain_pending, speaker_gain_code}), 18'hB9);
    rd(ADDR_SLOW_TICK, 9'h000);
    rd(ADDR_SPK_GAIN, 9'h079);
  endtask : t_reset
  task automatic wrap_up;
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    {reg_wr, sample_valid, mono_out_en, mono_src_sel, reg_addr, reg_wdata} = '0;
    {conv_sample, bypass_sample, aux_sample} = '0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_SLOW_TICK, 9'h000);
    rd(ADDR_SPK_SRC, 9'h000);
    rd(ADDR_SPK_GAIN, 9'h079);
    rd(7'h10, 9'h000);
    t_mix;
    t_gain;
    t_zc;
    t_timeout;
    t_reset;
    @(posedge sys_clk);
    mono_src_sel <= 3'h7;
    smp(100, 256, -7);
    chk(mono_out, 18'h0);
    @(posedge sys_clk);
    mono_out_en <= 1'b1;
    smp(100, 256, -7);
    chk(mono_out, 18'(349));
    wrap_up;
  end
  initial begin
    #20000;
    n_fail++;
    wrap_up;
  end
endmodule : speaker_output_gain_control_bench
